/* pkg/srd_pkg.sv */
// Purpose: Constants and carriers for the streaming read command decoder
// Assumes: 25 MHz controller clock, byte wide command-block port
// Notes:   Register indices are local to this block
package srd_pkg;

	// Command-block register indices (byte port address)
	localparam logic [3:0] SRD_ADR_FEATURE   = 4'h1;
	localparam logic [3:0] SRD_ADR_COUNT     = 4'h2;
	localparam logic [3:0] SRD_ADR_ADDR_LOW  = 4'h3;
	localparam logic [3:0] SRD_ADR_ADDR_MID  = 4'h4;
	localparam logic [3:0] SRD_ADR_ADDR_HIGH = 4'h5;
	localparam logic [3:0] SRD_ADR_UNIT      = 4'h6;
	localparam logic [3:0] SRD_ADR_OPCODE    = 4'h7;
	localparam logic [3:0] SRD_ADR_CONTROL   = 4'h8;
	localparam logic [3:0] SRD_ADR_UNIT_TIME = 4'h9;
	localparam logic [3:0] SRD_ADR_LOG       = 4'ha;

	// Opcode of the non-DMA streaming read
	localparam logic [7:0] SRD_OP_STREAM_READ = 8'h2b;

	// Feature field positions
	localparam int SRD_FB_EXPEDITE  = 7;
	localparam int SRD_FB_CONTINUE  = 6;
	localparam int SRD_FB_SCATTERED = 5;
	localparam int SRD_FB_RESUME    = 4;

	// Fault register bit positions
	localparam int SRD_EB_CHECKSUM  = 7;
	localparam int SRD_EB_UNRECOV   = 6;
	localparam int SRD_EB_NOTFOUND  = 4;
	localparam int SRD_EB_ABORTED   = 2;
	localparam int SRD_EB_TIMEOUT   = 0;

	// Condition and control register bit positions
	localparam int SRD_SB_BUSY      = 7;
	localparam int SRD_SB_READY     = 6;
	localparam int SRD_SB_STREAM    = 5;
	localparam int SRD_SB_FAULT     = 0;
	localparam int SRD_CB_HIGH_BYTE = 7;

	// Timing: one microsecond tick from the 25 MHz clock
	localparam int SRD_CLOCK_MHZ    = 25;
	localparam int SRD_TICK_NS      = 1000;
	localparam int SRD_CLOCK_NS     = 40;
	localparam int SRD_TICK_CYCLES  = SRD_TICK_NS / SRD_CLOCK_NS;

	// Reset values
	localparam logic [7:0]  SRD_RST_BYTE     = 8'h00;
	localparam logic [7:0]  SRD_RST_COND     = 8'h40;
	localparam logic [15:0] SRD_RST_UNIT     = 16'h0001;

	typedef enum logic [2:0] {
		SRD_IDLE = 3'b001,
		SRD_RUN  = 3'b010,
		SRD_DONE = 3'b100
	} srd_state_t;

	// A register pair: previous byte and current byte
	typedef struct packed {
		logic [7:0] prev;
		logic [7:0] cur;
	} srd_pair_t;

	// Command handed to the media side
	typedef struct packed {
		logic [2:0]  stream;
		logic [47:0] lba;
		logic [16:0] count;
		logic        expedite;
		logic        continuous;
		logic        scattered;
		logic        resume;
	} srd_cmd_t;

	// Per-sector result from the media side
	typedef struct packed {
		logic       valid;
		logic       checksum;
		logic       unrecov;
		logic       notfound;
		logic       aborted;
	} srd_sect_t;

endpackage : srd_pkg

/* core/srd_decode.sv */
// Purpose: Decode and run the streaming read command of the command block
// Assumes: Host writes previous byte then current byte of each register
// Notes:   Media side reports one result per sector; no data buffering
// Summary of operation
// - Expedite bit asks fastest completion within limit
// - Continue bit suppresses abort on faults
// - Continuous faults: full transfer, stream fault, log type
// - Continuous timeout: stop, stream fault, log timeout
// - Continue clear runs normal streaming read
// - Always try full amount within limit (here only in continuous mode; normal mode stops at the first fault)
// - Resume bit restarts at last fault address
// - Feature bits 2:0 select the stream
// - Limit is previous feature times unit microseconds
// - Zero limit uses stream default, else none
// - Time counts from opcode write to interrupt
// - Limit below minimum is raised to minimum
// - Count is sixteen bits, zero means 65536
// - Address is 48 bits from byte pairs
// - Fault address returned by high byte select
// - Fault bit 0 marks completion timeout
// - Continuous fault: first address, consecutive count, log
// - Opcode 2Bh starts the streaming read
//
// Our own choices: the strobed register port and the placing of the registers.
module srd_decode
	import srd_pkg::*;
#(
	parameter int          STREAMS      = 8,
	parameter logic [15:0] MIN_LIMIT_US = 16'h0001
)(
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        cfg_wr_i,
	input  wire logic [2:0]  cfg_stream_i,
	input  wire logic [15:0] cfg_limit_i,
	output srd_cmd_t         cmd_o,
	output logic             cmd_start_o,
	output logic             cmd_stop_o,
	input  wire srd_sect_t   sect_i,
	output logic             completion_interrupt_o
);

	typedef struct packed {
		srd_state_t  state;
		srd_pair_t   feat;
		srd_pair_t   count;
		srd_pair_t   a_low;
		srd_pair_t   a_mid;
		srd_pair_t   a_high;
		logic [7:0]  unit_sel;
		logic [7:0]  control;
		logic [15:0] unit_us;
		logic [7:0]  fault;
		logic [7:0]  cond;
		logic [7:0]  log;
		srd_cmd_t    cmd;
		logic [16:0] done_cnt;
		logic [47:0] bad_lba;
		logic [15:0] bad_run;
		logic        bad_seen;
		logic        run_open;
		logic [23:0] limit_us;
		logic        limit_on;
		logic [23:0] us_cnt;
		logic [4:0]  tick_cnt;
		logic        start;
		logic        stop;
		logic        irq;
		logic [7:0]  rdata;
		logic [STREAMS-1:0][15:0] dflt;
		logic [STREAMS-1:0][47:0] last_bad;
	} srd_reg_t;

	srd_reg_t s_r;
	srd_reg_t s_nxt;

	// Shift a new current byte in, pushing the old one to previous
	function automatic srd_pair_t srd_push(input srd_pair_t p,
		input logic [7:0] b);
		srd_pair_t q;
		q.prev = p.cur;
		q.cur  = b;
		return q;
	endfunction : srd_push

	// Pick previous byte when high byte select is set
	function automatic logic [7:0] srd_pick(input srd_pair_t p,
		input logic high_byte_select);
		return high_byte_select ? p.prev : p.cur;
	endfunction : srd_pick

	logic [23:0] req_us;
	logic [15:0] sel_dflt;
	logic [47:0] fault_lba;
	logic [16:0] sect_left;
	logic        any_fault;
	logic        tick;

	// Requested limit in microseconds and the stream default
	always_comb
	begin
		// Widen before the product so large units do not wrap at 16 bits
		req_us   = 24'(s_r.feat.prev) * 24'(s_r.unit_us);
		sel_dflt = s_r.dflt[s_r.feat.cur[2:0]];
		any_fault = sect_i.checksum | sect_i.unrecov |
			sect_i.notfound | sect_i.aborted;
		sect_left = s_r.cmd.count - s_r.done_cnt;
		tick = (s_r.tick_cnt == 5'(SRD_TICK_CYCLES - 1));
		fault_lba = s_r.cmd.lba + 48'(s_r.done_cnt);
	end

	// Whole next-state computation
	always_comb
	begin
		s_nxt       = s_r;
		s_nxt.start = 1'b0;
		s_nxt.stop  = 1'b0;
		s_nxt.irq   = 1'b0;
		s_nxt.rdata = SRD_RST_BYTE;

		// Default limits from the stream configuration path
		if (cfg_wr_i)
			s_nxt.dflt[cfg_stream_i] = cfg_limit_i;

		// Register writes are only honoured while not busy
		if (wr_i && s_r.state != SRD_RUN)
		begin
			case (addr_i)
				SRD_ADR_FEATURE:   s_nxt.feat   = srd_push(s_r.feat, wdata_i);
				SRD_ADR_COUNT:     s_nxt.count  = srd_push(s_r.count, wdata_i);
				SRD_ADR_ADDR_LOW:  s_nxt.a_low  = srd_push(s_r.a_low, wdata_i);
				SRD_ADR_ADDR_MID:  s_nxt.a_mid  = srd_push(s_r.a_mid, wdata_i);
				SRD_ADR_ADDR_HIGH: s_nxt.a_high = srd_push(s_r.a_high, wdata_i);
				SRD_ADR_UNIT:      s_nxt.unit_sel = wdata_i;
				SRD_ADR_CONTROL:   s_nxt.control  = wdata_i;
				SRD_ADR_UNIT_TIME: s_nxt.unit_us  =
					{s_r.unit_us[7:0], wdata_i};
				default: ;
			endcase
		end

		// Opcode write launches the command
		if (wr_i && addr_i == SRD_ADR_OPCODE && s_r.state != SRD_RUN)
		begin
			if (wdata_i == SRD_OP_STREAM_READ)
			begin
				s_nxt.cmd.stream     = s_r.feat.cur[2:0];
				s_nxt.cmd.expedite   = s_r.feat.cur[SRD_FB_EXPEDITE];
				s_nxt.cmd.continuous = s_r.feat.cur[SRD_FB_CONTINUE];
				s_nxt.cmd.scattered  = s_r.feat.cur[SRD_FB_SCATTERED];
				s_nxt.cmd.resume     = s_r.feat.cur[SRD_FB_RESUME];
				// Address from previous and current bytes
				s_nxt.cmd.lba = {s_r.a_high.prev, s_r.a_mid.prev,
					s_r.a_low.prev, s_r.a_high.cur, s_r.a_mid.cur,
					s_r.a_low.cur};
				// Resume uses the stream's last fault address
				if (s_r.feat.cur[SRD_FB_RESUME])
					s_nxt.cmd.lba = s_r.last_bad[s_r.feat.cur[2:0]];
				s_nxt.cmd.count = ({s_r.count.prev, s_r.count.cur} == 16'h0000)
					? 17'h10000
					: {1'b0, s_r.count.prev, s_r.count.cur};
				// Choose the limit
				if (req_us != 24'h000000)
				begin
					s_nxt.limit_on = 1'b1;
					s_nxt.limit_us = req_us;
				end
				else
				begin
					s_nxt.limit_on = (sel_dflt != 16'h0000);
					s_nxt.limit_us = 24'(sel_dflt) * 24'(s_r.unit_us);
				end
				if (s_nxt.limit_on && s_nxt.limit_us < 24'(MIN_LIMIT_US))
					s_nxt.limit_us = 24'(MIN_LIMIT_US);
				s_nxt.us_cnt   = 24'h000000;
				s_nxt.tick_cnt = 5'h00;
				s_nxt.done_cnt = 17'h00000;
				s_nxt.bad_seen = 1'b0;
				s_nxt.run_open = 1'b0;
				s_nxt.bad_run  = 16'h0000;
				s_nxt.fault    = SRD_RST_BYTE;
				s_nxt.log      = SRD_RST_BYTE;
				s_nxt.cond     = 8'h80;
				s_nxt.start    = 1'b1;
				s_nxt.state    = SRD_RUN;
			end
			else
			begin
				// Unknown opcode: abort at once
				s_nxt.fault = 8'h04;
				s_nxt.cond  = SRD_RST_COND | 8'h01;
				s_nxt.irq   = 1'b1;
				s_nxt.state = SRD_DONE;
			end
		end

		case (s_r.state)
			SRD_IDLE, SRD_DONE: ;
			SRD_RUN:
			begin
				// Microsecond timer from opcode write
				s_nxt.tick_cnt = tick ? 5'h00 : s_r.tick_cnt + 5'h01;
				if (tick)
					s_nxt.us_cnt = s_r.us_cnt + 24'h000001;
				if (sect_i.valid)
				begin
					s_nxt.done_cnt = s_r.done_cnt + 17'h00001;
					if (any_fault)
					begin
						// Record first fault and its run length
						if (!s_r.bad_seen)
						begin
							s_nxt.bad_seen = 1'b1;
							s_nxt.run_open = 1'b1;
							s_nxt.bad_lba  = fault_lba;
							s_nxt.bad_run  = 16'h0001;
							s_nxt.last_bad[s_r.cmd.stream] = fault_lba;
						end
						else if (s_r.run_open)
							s_nxt.bad_run = s_r.bad_run + 16'h0001;
						s_nxt.log = s_r.log |
							{sect_i.checksum, sect_i.unrecov, 1'b0,
							sect_i.notfound, 1'b0, sect_i.aborted,
							2'b00};
					end
					else
						s_nxt.run_open = 1'b0;
					// Normal mode stops at the first fault
					if (any_fault && !s_r.cmd.continuous)
					begin
						s_nxt.fault = {sect_i.checksum, sect_i.unrecov, 1'b0,
							sect_i.notfound, 1'b0, sect_i.aborted, 2'b00};
						s_nxt.cond  = SRD_RST_COND | 8'h01;
						s_nxt.stop  = 1'b1;
						s_nxt.irq   = 1'b1;
						s_nxt.state = SRD_DONE;
					end
					else if (sect_left == 17'h00001)
					begin
						// Full amount moved
						s_nxt.cond  = SRD_RST_COND |
							((s_nxt.bad_seen && s_r.cmd.continuous)
							? 8'h20 : 8'h00);
						s_nxt.irq   = 1'b1;
						s_nxt.state = SRD_DONE;
					end
				end
				// Time limit expiry ends the command
				if (s_r.limit_on && s_r.us_cnt >= s_r.limit_us &&
					s_nxt.state == SRD_RUN)
				begin
					s_nxt.stop = 1'b1;
					s_nxt.irq  = 1'b1;
					s_nxt.state = SRD_DONE;
					if (s_r.cmd.continuous)
					begin
						s_nxt.log  = s_nxt.log | 8'h01;
						s_nxt.cond = SRD_RST_COND | 8'h20;
					end
					else
					begin
						s_nxt.fault = s_nxt.fault | 8'h01;
						s_nxt.cond  = SRD_RST_COND | 8'h01;
					end
				end
			end
			default: s_nxt.state = SRD_IDLE;
		endcase

		// Register reads; fault address replaces input bytes after a sector fault
		if (rd_i)
		begin
			case (addr_i)
				SRD_ADR_FEATURE:   s_nxt.rdata = s_r.fault;
				SRD_ADR_COUNT:     s_nxt.rdata =
					s_r.bad_seen && s_r.cmd.continuous
					? (s_r.control[SRD_CB_HIGH_BYTE] ? s_r.bad_run[15:8]
					: s_r.bad_run[7:0])
					: srd_pick(s_r.count, s_r.control[SRD_CB_HIGH_BYTE]);
				SRD_ADR_ADDR_LOW:  s_nxt.rdata = s_r.bad_seen
					? (s_r.control[SRD_CB_HIGH_BYTE] ? s_r.bad_lba[31:24]
					: s_r.bad_lba[7:0])
					: srd_pick(s_r.a_low, s_r.control[SRD_CB_HIGH_BYTE]);
				SRD_ADR_ADDR_MID:  s_nxt.rdata = s_r.bad_seen
					? (s_r.control[SRD_CB_HIGH_BYTE] ? s_r.bad_lba[39:32]
					: s_r.bad_lba[15:8])
					: srd_pick(s_r.a_mid, s_r.control[SRD_CB_HIGH_BYTE]);
				SRD_ADR_ADDR_HIGH: s_nxt.rdata = s_r.bad_seen
					? (s_r.control[SRD_CB_HIGH_BYTE] ? s_r.bad_lba[47:40]
					: s_r.bad_lba[23:16])
					: srd_pick(s_r.a_high, s_r.control[SRD_CB_HIGH_BYTE]);
				SRD_ADR_UNIT:      s_nxt.rdata = s_r.unit_sel;
				SRD_ADR_OPCODE:    s_nxt.rdata = s_r.cond;
				SRD_ADR_CONTROL:   s_nxt.rdata = s_r.control;
				SRD_ADR_UNIT_TIME: s_nxt.rdata = s_r.unit_us[7:0];
				SRD_ADR_LOG:       s_nxt.rdata = s_r.log;
				default:           s_nxt.rdata = SRD_RST_BYTE;
			endcase
		end
	end

	// State register; synchronous reset to constants
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			s_r          <= '0;
			s_r.state    <= SRD_IDLE;
			s_r.cond     <= SRD_RST_COND;
			s_r.unit_us  <= SRD_RST_UNIT;
		end
		else
			s_r <= s_nxt;
	end

	// Outputs straight from flip-flops
	assign rdata_o                = s_r.rdata;
	assign cmd_o                  = s_r.cmd;
	assign cmd_start_o            = s_r.start;
	assign cmd_stop_o             = s_r.stop;
	assign completion_interrupt_o = s_r.irq;

endmodule : srd_decode

/* tb/srd_decode_monitor.sv */
// Purpose: Port checker for the streaming read decoder
// Assumes: One clock, synchronous active low reset
// Notes:   Busy is rebuilt here from the launch and completion pulses
module srd_decode_monitor
	import srd_pkg::*;
(
	input wire logic       clock_i,
	input wire logic       rst_b_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire srd_cmd_t   cmd_o,
	input wire logic       cmd_start_o,
	input wire logic       cmd_stop_o,
	input wire srd_sect_t  sect_i,
	input wire logic       completion_interrupt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dcb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	logic busy_r;
	logic op_wr;
	logic bad_sect;
	// Opcode write while idle, and an unrecoverable sector while running
	assign op_wr = wr_i && addr_i == SRD_ADR_OPCODE && !busy_r && !cmd_start_o;
	assign bad_sect = busy_r && sect_i.valid && sect_i.unrecov;
	// Busy from launch until completion
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i || completion_interrupt_o)
			busy_r <= 1'b0;
		else if (cmd_start_o)
			busy_r <= 1'b1;
	end
	chk_launch_next: assert property (
		op_wr && wdata_i == SRD_OP_STREAM_READ |=> cmd_start_o)
		else $error("no launch after opcode write");
	chk_bad_refused: assert property (
		op_wr && wdata_i != SRD_OP_STREAM_READ
		|=> !cmd_start_o ##[0:3] completion_interrupt_o)
		else $error("unknown opcode not refused");
	chk_read_quiet: assert property (
		!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside its cycle");
	chk_cmd_holds: assert property (
		!cmd_start_o |-> $stable(cmd_o))
		else $error("command changed without launch");
	chk_cont_no_stop: assert property (
		bad_sect && cmd_o.continuous |=> !cmd_stop_o [*2])
		else $error("continuous mode stopped on fault");
	chk_normal_stop: assert property (
		bad_sect && !cmd_o.continuous |-> ##[1:2] cmd_stop_o)
		else $error("normal mode kept going after fault");
	chk_stop_ends: assert property (
		cmd_stop_o |-> busy_r ##[0:2] completion_interrupt_o)
		else $error("stop without completion");
	chk_int_pulse: assert property (
		completion_interrupt_o |=> !completion_interrupt_o)
		else $error("completion longer than a pulse");
	chk_count_range: assert property (
		cmd_start_o |-> cmd_o.count != 17'h0 && cmd_o.count <= 17'h10000)
		else $error("sector count out of range");
endmodule : srd_decode_monitor

bind srd_decode srd_decode_monitor u_srd_decode_monitor (.clock_i, .rst_b_i,
	.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cmd_o, .cmd_start_o,
	.cmd_stop_o, .sect_i, .completion_interrupt_o);

/* tb/srd_media.sv */
// Purpose: Media side model giving one result per sector
// Assumes: Launch and stop pulses from the decoder
// Notes:   One chosen sector is reported unreadable; gap sets the pace
module srd_media
	import srd_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rst_b_i,
	input  wire srd_cmd_t   cmd_i,
	input  wire logic       start_i,
	input  wire logic       stop_i,
	input  wire logic [7:0] fault_at_i,
	input  wire logic [1:0] gap_i,
	output srd_sect_t       sect_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [16:0] left_r;
	logic [7:0]  idx_r;
	logic [1:0]  wait_r;
	// Sectors until the count runs out; a stop cuts the run short
	always_ff @(posedge clock_i)
	begin
		sect_o <= '0;
		if (!rst_b_i || stop_i)
			left_r <= '0;
		else if (start_i)
		begin
			left_r <= cmd_i.count;
			idx_r <= 8'h00;
			wait_r <= gap_i;
		end
		else if (left_r != 17'h0 && wait_r != 2'h0)
			wait_r <= wait_r - 2'h1;
		else if (left_r != 17'h0)
		begin
			sect_o.valid <= 1'b1;
			sect_o.unrecov <= idx_r + 8'h01 == fault_at_i;
			idx_r <= idx_r + 8'h01;
			left_r <= left_r - 17'h1;
			wait_r <= gap_i;
		end
	end
endmodule : srd_media

/* tb/tb.sv */
// Purpose: Self-checking bench for the streaming read decoder
// Assumes: Media model paces sectors; 25 MHz clock
// Notes:   Raised two microsecond minimum keeps limits short
module tb import srd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i, rst_b_i, wr_i, rd_i, cfg_wr_i;
	logic [3:0]  addr_i;
	logic [7:0]  wdata_i, rdata_o, fault_at;
	logic [2:0]  cfg_stream_i;
	logic [15:0] cfg_limit_i;
	srd_cmd_t    cmd_o;
	srd_sect_t   sect_i;
	logic        cmd_start_o, cmd_stop_o, completion_interrupt_o;
	logic [1:0]  gap;
	int          n_errors, compares;
	srd_decode #(.MIN_LIMIT_US(16'h0002)) u_srd_decode (.clock_i, .rst_b_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cfg_wr_i, .cfg_stream_i,
		.cfg_limit_i, .cmd_o, .cmd_start_o, .cmd_stop_o, .sect_i,
		.completion_interrupt_o);
	srd_media u_srd_media (.clock_i, .rst_b_i, .cmd_i(cmd_o),
		.start_i(cmd_start_o), .stop_i(cmd_stop_o), .fault_at_i(fault_at),
		.gap_i(gap), .sect_o(sect_i));
	// Free running clock
	initial
	begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	task automatic summarize();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	task automatic tally(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1)
		begin
			n_errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : tally
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		tally(rdata_o === e, "read data");
	endtask : rd
	// Expected launch from the feature, count and address bytes
	function automatic srd_cmd_t exp_cmd(input logic [7:0] f,
		input logic [15:0] c, input logic [47:0] a);
		return {f[2:0], a, c == 16'h0 ? 17'h10000 : {1'b0, c},
			f[SRD_FB_EXPEDITE], f[SRD_FB_CONTINUE], f[SRD_FB_SCATTERED],
			f[SRD_FB_RESUME]};
	endfunction : exp_cmd
	task automatic run(input logic [7:0] fp, f, input logic [15:0] c,
		input logic [47:0] a, e, input logic [7:0] fa, input logic [1:0] g);
		wr(SRD_ADR_FEATURE, fp);
		fault_at <= fa;
		gap <= g;
		wr(SRD_ADR_FEATURE, f);
		wr(SRD_ADR_COUNT, c[15:8]);
		wr(SRD_ADR_COUNT, c[7:0]);
		wr(SRD_ADR_ADDR_LOW, a[31:24]);
		wr(SRD_ADR_ADDR_LOW, a[7:0]);
		wr(SRD_ADR_ADDR_MID, a[39:32]);
		wr(SRD_ADR_ADDR_MID, a[15:8]);
		wr(SRD_ADR_ADDR_HIGH, a[47:40]);
		wr(SRD_ADR_ADDR_HIGH, a[23:16]);
		wr(SRD_ADR_OPCODE, SRD_OP_STREAM_READ);
		#1;
		tally(cmd_o === exp_cmd(f, c, e) && cmd_start_o, "launch");
	endtask : run
	// Bounded wait for completion; the count starts at launch
	task automatic done(output int n);
		n = 0;
		#1;
		while (completion_interrupt_o !== 1'b1)
		begin
			@(posedge clock_i);
			#1;
			n++;
			if (n > 3000)
			begin
				n_errors++;
				summarize();
			end
		end
	endtask : done
	task automatic tmo(input logic [7:0] fp, f, input int lim,
		input logic [7:0] cond, input logic [3:0] where);
		int n;
		run(fp, f, 16'h0000, 48'h0, 48'h0, 8'h00, 2'h3);
		done(n);
		tally(n >= lim * 25 - 2 && n <= lim * 25 + 2, "limit");
		rd(SRD_ADR_OPCODE, cond);
		rd(where, 8'h01);
	endtask : tmo
	// Main sequence: reset, random launches, then corner cases
	initial
	begin
		logic [7:0]  f;
		logic [47:0] a;
		int          n;
		{rst_b_i, wr_i, rd_i, cfg_wr_i, addr_i, wdata_i} = '0;
		{cfg_stream_i, cfg_limit_i, fault_at, gap} = '0;
		n_errors = 0;
		compares = 0;
		n = $urandom(32'hb0a4);
		repeat (12) @(posedge clock_i);
		rst_b_i <= 1'b1;
		rd(SRD_ADR_OPCODE, SRD_RST_COND);
		rd(4'hf, 8'h00);
		rd(SRD_ADR_UNIT_TIME, SRD_RST_UNIT[7:0]);
		repeat (6)
		begin
			f = 8'($urandom) & 8'he7;
			a = {16'($urandom), 32'($urandom)};
			run(8'h00, f, 16'($urandom_range(4, 1)), a, a, 0, 2'($urandom));
			done(n);
			rd(SRD_ADR_OPCODE, 8'h40);
		end
		run(8'h00, 8'h03, 16'h0004, 48'h10, 48'h10, 8'h02, 2'h1);
		done(n);
		rd(SRD_ADR_FEATURE, 8'h40);
		rd(SRD_ADR_ADDR_LOW, 8'h11);
		run(8'h00, 8'h13, 16'h0001, 48'h0, 48'h11, 8'h00, 2'h0);
		done(n);
		run(8'h00, 8'h42, 16'h0003, 48'h20, 48'h20, 8'h02, 2'h3);
		rd(SRD_ADR_OPCODE, 8'h80);
		done(n);
		rd(SRD_ADR_OPCODE, 8'h60);
		rd(SRD_ADR_LOG, 8'h40);
		rd(SRD_ADR_FEATURE, 8'h00);
		rd(SRD_ADR_ADDR_LOW, 8'h21);
		rd(SRD_ADR_COUNT, 8'h01);
		tmo(8'h01, 8'h01, 2, 8'h41, SRD_ADR_FEATURE);
		tmo(8'h03, 8'h41, 3, 8'h60, SRD_ADR_LOG);
		@(posedge clock_i);
		{cfg_wr_i, cfg_stream_i, cfg_limit_i} <= {1'b1, 3'h6, 16'h0003};
		@(posedge clock_i);
		cfg_wr_i <= 1'b0;
		tmo(8'h00, 8'h86, 3, 8'h41, SRD_ADR_FEATURE);
		wr(SRD_ADR_OPCODE, 8'h24);
		done(n);
		rd(SRD_ADR_FEATURE, 8'h04);
		summarize();
	end
endmodule : tb
